// *** rtl/spsf_pkg.sv ***
// register map, flag layout and receiver timing shared by the status-flag block
// assumes an APB slave with 32-bit data and 16x oversampling of the receive line
package spsf_pkg;
  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_BAUD = 8'h0c;
  // ==========================================================================
  // serial_status_one bit positions
  localparam int ST_PAR_ERR = 0;
  localparam int ST_STOP_ERR = 1;
  localparam int ST_NOISE = 2;
  localparam int ST_OR = 3;
  localparam int ST_IDLE = 4;
  localparam int ST_RX_FULL = 5;
  localparam int ST_TX_DONE = 6;
  localparam int ST_TX_EMPTY = 7;
  localparam logic [7:0] STATUS_RST = 8'hc0;
  localparam logic [7:0] RX_FLAG_MASK = 8'h3f;
  localparam logic [7:0] TX_FLAG_MASK = 8'hc0;
  localparam logic [7:0] TX_DONE_MASK = 8'h40;
  // ==========================================================================
  // serial_control_two bit positions
  localparam int CT_BREAK = 0;
  localparam int CT_TX_EN = 3;
  localparam int CT_NINE = 4;
  localparam int CT_PAR_EN = 5;
  localparam int CT_ODD = 6;
  localparam int CT_IDLE_SEL = 7;
  localparam logic [7:0] CTRL_MASK = 8'hf9;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] BAUD_RST = 16'h0036;
  // ==========================================================================
  // bit timing in oversample ticks, character lengths in bit times
  localparam logic [3:0] PH_END = 4'hf;
  localparam logic [3:0] START_FIRST = 4'h4;
  localparam logic [3:0] START_LAST = 4'ha;
  localparam logic [3:0] MID_FIRST = 4'h7;
  localparam logic [3:0] MID_LAST = 4'h9;
  localparam logic [3:0] CHAR_BITS_8 = 4'ha;
  localparam logic [3:0] CHAR_BITS_9 = 4'hb;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} spsf_rx_state_t;
endpackage

// *** rtl/spsf_rx.sv ***
// receive shifter with majority sampling and idle-line timing
// assumes rxd already synchronised and tick pulsing sixteen times per bit
`timescale 1ns/1ns
`default_nettype none
module spsf_rx (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic rxd,
  input wire logic nine_bit,
  input wire logic parity_en,
  input wire logic parity_odd,
  input wire logic idle_sel,
  output logic char_done,
  output logic [7:0] char_data,
  output logic char_noise,
  output logic char_frame_err,
  output logic char_parity_err,
  output logic idle_seen
);
  spsf_pkg::spsf_rx_state_t state_q;
  logic [3:0] phase_q;
  logic [3:0] bit_cnt_q;
  logic [3:0] idle_cnt_q;
  logic [6:0] start_smp_q;
  logic [2:0] mid_smp_q;
  logic [8:0] bits_q;
  logic noise_q;

  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  // ==========================================================================
  // sampling decode
  wire bit_end = tick & (phase_q == spsf_pkg::PH_END);
  wire in_start_win = (phase_q >= spsf_pkg::START_FIRST) && (phase_q <= spsf_pkg::START_LAST);
  wire in_mid_win = (phase_q >= spsf_pkg::MID_FIRST) && (phase_q <= spsf_pkg::MID_LAST);
  wire start_ok = ~maj3(start_smp_q[3:1]);
  wire start_noisy = |start_smp_q;
  wire bit_val = maj3(mid_smp_q);
  wire bit_noisy = ~((&mid_smp_q) | ~(|mid_smp_q));
  wire [3:0] last_bit = nine_bit ? 4'h8 : 4'h7;
  wire rx_parity = nine_bit ? ^bits_q : ^bits_q[8:1];
  wire [3:0] idle_limit = nine_bit ? spsf_pkg::CHAR_BITS_9 : spsf_pkg::CHAR_BITS_8;
  wire start_seen = (state_q == spsf_pkg::RX_IDLE) & tick & ~rxd;
  wire in_frame = (state_q == spsf_pkg::RX_DATA) | (state_q == spsf_pkg::RX_STOP);

  // ==========================================================================
  // idle bit-time counting; counting restarts after the start bit, or after the stop bit when idle_sel is set
  wire idle_clr = start_seen | (bit_end & in_frame & (idle_sel | ~bit_val));
  wire idle_step = bit_end & ~idle_clr & ((state_q == spsf_pkg::RX_IDLE) | in_frame);
  wire idle_hit = idle_step & (idle_cnt_q != idle_limit);

  always_ff @(posedge clk) begin
    if (rst) begin
      idle_cnt_q <= 4'h0;
      idle_seen <= 1'b0;
    end else begin
      if (idle_clr) begin
        idle_cnt_q <= 4'h0;
      end else if (idle_hit) begin
        idle_cnt_q <= idle_cnt_q + 4'h1;
      end
      // saturating count gives one pulse per idle stretch
      idle_seen <= idle_hit & (idle_cnt_q + 4'h1 == idle_limit);
    end
  end

  // ==========================================================================
  // frame sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= spsf_pkg::RX_IDLE;
      phase_q <= 4'h0;
      bit_cnt_q <= 4'h0;
      start_smp_q <= 7'h00;
      mid_smp_q <= 3'h0;
      bits_q <= 9'h000;
      noise_q <= 1'b0;
      char_done <= 1'b0;
      char_data <= 8'h00;
      char_noise <= 1'b0;
      char_frame_err <= 1'b0;
      char_parity_err <= 1'b0;
    end else begin
      char_done <= 1'b0;
      if (tick) begin
        phase_q <= start_seen ? 4'h1 : phase_q + 4'h1;
        if (in_start_win) begin
          start_smp_q <= {start_smp_q[5:0], rxd};
        end
        if (in_mid_win) begin
          mid_smp_q <= {mid_smp_q[1:0], rxd};
        end
      end
      unique case (state_q)
        spsf_pkg::RX_IDLE: begin
          if (start_seen) begin
            state_q <= spsf_pkg::RX_START;
          end
        end
        spsf_pkg::RX_START: begin
          if (bit_end) begin
            state_q <= start_ok ? spsf_pkg::RX_DATA : spsf_pkg::RX_IDLE;
            noise_q <= start_noisy;
            bit_cnt_q <= 4'h0;
          end
        end
        spsf_pkg::RX_DATA: begin
          if (bit_end) begin
            bits_q <= {bit_val, bits_q[8:1]};
            noise_q <= noise_q | bit_noisy;
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == last_bit) begin
              state_q <= spsf_pkg::RX_STOP;
            end
          end
        end
        spsf_pkg::RX_STOP: begin
          if (bit_end) begin
            state_q <= spsf_pkg::RX_IDLE;
            char_done <= 1'b1;
            char_data <= nine_bit ? bits_q[7:0] : bits_q[8:1];
            char_noise <= noise_q | bit_noisy;
            char_frame_err <= ~bit_val;
            char_parity_err <= parity_en & (rx_parity != parity_odd);
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** rtl/spsf_top.sv ***
// status-flag logic of an asynchronous serial port, with APB register access
// assumes CLK at 100 MHz, synchronous active-high RST, RXD asynchronous to CLK
//
// Function
// - transmit-complete is set after reset and when idle with empty buffer
// - transmit-complete clears after status read, then data write, enable rise or break
// - receive-full sets when a character moves into the data register
// - receive-full clears by status read with it set, then data read
// - idle flag sets after 10 or 11 high bit times following activity
// - idle-type clear: idle counting starts right after the start bit
// - idle-type set: idle counting starts only after the stop bit
// - idle flag clears by status read with it set, then data read
// - idle flag sets once per idle stretch and rearms on a new character
// - overrun sets when a character arrives unread; new character is discarded
// - overrun clears by status read with it set, then data read
// - seven start samples, three per bit; disagreement sets noise with receive-full
// - noise flag clears by status read, then data read
// - framing error sets with receive-full when the stop bit samples low
// - framing error clears by status read with it set, then data read
// - parity error sets with receive-full when enabled parity mismatches
// - parity error clears by status read, then data read
// - status flags are read-only; writes to the status register do nothing
// - buffer-empty sets at reset and on shifter load; clears by read then write
`timescale 1ns/1ns
`default_nettype none
module spsf_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RXD,
  output logic TXD
);
  logic [7:0] flag_q;
  logic [7:0] snap_q;
  logic [7:0] ctrl_q;
  logic [15:0] baud_q;
  logic [15:0] baud_cnt_q;
  logic [7:0] rx_data_q;
  logic idle_armed_q;
  logic rxd_meta_q;
  logic rxd_sync_q;
  logic [7:0] tx_buf_q;
  logic [10:0] tx_shift_q;
  logic [3:0] tx_left_q;
  logic [3:0] tx_phase_q;
  logic tx_busy_q;
  logic pre_pend_q;
  logic brk_pend_q;
  logic char_done;
  logic [7:0] char_data;
  logic char_noise;
  logic char_frame_err;
  logic char_parity_err;
  logic idle_seen;
  logic [7:0] set_v;

  // ==========================================================================
  // bus decode
  wire access = PSEL & PENABLE;
  wire done = access & PREADY;
  wire sel_status = PADDR == spsf_pkg::ADDR_STATUS;
  wire sel_data = PADDR == spsf_pkg::ADDR_DATA;
  wire sel_ctrl = PADDR == spsf_pkg::ADDR_CTRL;
  wire sel_baud = PADDR == spsf_pkg::ADDR_BAUD;
  wire mapped = sel_status | sel_data | sel_ctrl | sel_baud;
  wire status_rd = done & ~PWRITE & sel_status;
  wire data_rd = done & ~PWRITE & sel_data;
  wire data_wr = done & PWRITE & sel_data;
  wire ctrl_wr = done & PWRITE & sel_ctrl;
  wire baud_wr = done & PWRITE & sel_baud;
  wire [31:0] rdata_mux = sel_status ? {24'h000000, flag_q} :
                          sel_data ? {24'h000000, rx_data_q} :
                          sel_ctrl ? {24'h000000, ctrl_q} :
                          sel_baud ? {16'h0000, baud_q} : 32'h00000000;

  // two-cycle access phase: data is latched one edge before PREADY is seen
  always_ff @(posedge CLK) begin
    if (RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end else begin
      PREADY <= access & ~PREADY;
      PSLVERR <= access & ~PREADY & ~mapped;
      if (access & ~PREADY & ~PWRITE) begin
        PRDATA <= rdata_mux;
      end
    end
  end

  // ==========================================================================
  // control and baud registers; the status register takes no write
  wire tx_en = ctrl_q[spsf_pkg::CT_TX_EN];
  wire brk_bit = ctrl_q[spsf_pkg::CT_BREAK];
  wire nine = ctrl_q[spsf_pkg::CT_NINE];
  wire par_en = ctrl_q[spsf_pkg::CT_PAR_EN];
  wire odd = ctrl_q[spsf_pkg::CT_ODD];
  wire tx_en_rise = ctrl_wr & PWDATA[spsf_pkg::CT_TX_EN] & ~tx_en;
  wire brk_set = ctrl_wr & PWDATA[spsf_pkg::CT_BREAK];
  wire tick = (baud_cnt_q + 16'h0001) >= baud_q;

  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_q <= spsf_pkg::CTRL_RST;
      baud_q <= spsf_pkg::BAUD_RST;
      baud_cnt_q <= 16'h0000;
    end else begin
      if (ctrl_wr) begin
        ctrl_q <= PWDATA[7:0] & spsf_pkg::CTRL_MASK;
      end
      if (baud_wr) begin
        baud_q <= PWDATA[15:0];
      end
      baud_cnt_q <= tick ? 16'h0000 : baud_cnt_q + 16'h0001;
    end
  end

  // ==========================================================================
  // receive path
  always_ff @(posedge CLK) begin
    if (RST) begin
      rxd_meta_q <= 1'b1;
      rxd_sync_q <= 1'b1;
    end else begin
      rxd_meta_q <= RXD;
      rxd_sync_q <= rxd_meta_q;
    end
  end

  spsf_rx u_rx (
    .clk(CLK),
    .rst(RST),
    .tick(tick),
    .rxd(rxd_sync_q),
    .nine_bit(nine),
    .parity_en(par_en),
    .parity_odd(odd),
    .idle_sel(ctrl_q[spsf_pkg::CT_IDLE_SEL]),
    .char_done(char_done),
    .char_data(char_data),
    .char_noise(char_noise),
    .char_frame_err(char_frame_err),
    .char_parity_err(char_parity_err),
    .idle_seen(idle_seen)
  );

  // ==========================================================================
  // clearing sequences
  // only flags captured by the last status read may be cleared
  wire done_kick = data_wr | tx_en_rise | brk_set;
  wire [7:0] acc_mask = ({8{data_rd}} & spsf_pkg::RX_FLAG_MASK) |
                        ({8{data_wr}} & spsf_pkg::TX_FLAG_MASK) |
                        ({8{tx_en_rise | brk_set}} & spsf_pkg::TX_DONE_MASK);
  wire [7:0] clr_v = snap_q & acc_mask;
  // a character read out in the same cycle frees the register for the next
  wire accept = char_done &
                (~flag_q[spsf_pkg::ST_RX_FULL] | clr_v[spsf_pkg::ST_RX_FULL]);

  // ==========================================================================
  // transmit path
  wire data_par = (^(nine ? tx_buf_q : {1'b0, tx_buf_q[6:0]})) ^ odd;
  wire [10:0] data_frame = nine ? {1'b1, par_en ? data_par : 1'b0, tx_buf_q, 1'b0} :
                                  {2'b11, par_en ? data_par : tx_buf_q[7], tx_buf_q[6:0], 1'b0};
  wire tx_idle = ~tx_busy_q & tx_en;
  wire start_brk = tx_idle & (brk_pend_q | brk_bit);
  wire start_pre = tx_idle & ~start_brk & pre_pend_q;
  wire tx_load = tx_idle & ~start_brk & ~start_pre & ~flag_q[spsf_pkg::ST_TX_EMPTY];
  wire tx_start = start_brk | start_pre | tx_load;
  wire tx_bit_end = tx_busy_q & tick & (tx_phase_q == spsf_pkg::PH_END);
  wire done_cond = flag_q[spsf_pkg::ST_TX_EMPTY] & ~tx_busy_q & ~pre_pend_q &
                   ~(tx_en & (brk_pend_q | brk_bit));

  always_ff @(posedge CLK) begin
    if (RST) begin
      tx_buf_q <= 8'h00;
      tx_shift_q <= 11'h7ff;
      tx_left_q <= 4'h0;
      tx_phase_q <= 4'h0;
      tx_busy_q <= 1'b0;
      pre_pend_q <= 1'b0;
      brk_pend_q <= 1'b0;
      TXD <= 1'b1;
    end else begin
      if (data_wr) begin
        tx_buf_q <= PWDATA[7:0];
      end
      if (tx_en_rise) begin
        pre_pend_q <= 1'b1;
      end else if (start_pre) begin
        pre_pend_q <= 1'b0;
      end
      if (brk_set) begin
        brk_pend_q <= 1'b1;
      end else if (start_brk) begin
        brk_pend_q <= 1'b0;
      end
      if (tx_start) begin
        tx_busy_q <= 1'b1;
        tx_phase_q <= 4'h0;
        tx_left_q <= nine ? spsf_pkg::CHAR_BITS_9 : spsf_pkg::CHAR_BITS_8;
        tx_shift_q <= start_brk ? 11'h000 : start_pre ? 11'h7ff : data_frame;
      end else if (tx_busy_q && tick) begin
        tx_phase_q <= tx_phase_q + 4'h1;
        if (tx_bit_end) begin
          tx_shift_q <= {1'b1, tx_shift_q[10:1]};
          tx_left_q <= tx_left_q - 4'h1;
          tx_busy_q <= tx_left_q != 4'h1;
        end
      end
      TXD <= tx_busy_q ? tx_shift_q[0] : 1'b1;
    end
  end

  // ==========================================================================
  // status flags: set always wins over clear
  assign set_v[spsf_pkg::ST_PAR_ERR] = accept & char_parity_err;
  assign set_v[spsf_pkg::ST_STOP_ERR] = accept & char_frame_err;
  assign set_v[spsf_pkg::ST_NOISE] = accept & char_noise;
  assign set_v[spsf_pkg::ST_OR] = char_done & ~accept;
  assign set_v[spsf_pkg::ST_IDLE] = idle_seen & idle_armed_q;
  assign set_v[spsf_pkg::ST_RX_FULL] = accept;
  // the kick itself starts activity, so it keeps the flag from re-setting
  assign set_v[spsf_pkg::ST_TX_DONE] = done_cond & ~done_kick;
  assign set_v[spsf_pkg::ST_TX_EMPTY] = tx_load;

  always_ff @(posedge CLK) begin
    if (RST) begin
      flag_q <= spsf_pkg::STATUS_RST;
      snap_q <= 8'h00;
      rx_data_q <= 8'h00;
      idle_armed_q <= 1'b0;
    end else begin
      flag_q <= (flag_q & ~clr_v) | set_v;
      snap_q <= status_rd ? PRDATA[7:0] : snap_q & ~acc_mask;
      if (accept) begin
        rx_data_q <= char_data;
      end
      if (accept) begin
        idle_armed_q <= 1'b1;
      end else if (set_v[spsf_pkg::ST_IDLE]) begin
        idle_armed_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/spsf_chk.sv ***
// checker for the serial status-flag block, watching only its top-level ports
// assumes one clock domain and the synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module spsf_chk (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic RXD,
  input wire logic TXD
);
  // ==========================================================================
  // bus timing and status read relations
  wire logic mapped;
  wire logic st_rd;
  assign mapped = PADDR <= spsf_pkg::ADDR_BAUD && PADDR[1:0] == 2'b00;
  assign st_rd = PREADY && !PWRITE && PADDR == spsf_pkg::ADDR_STATUS;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_setup; PSEL && !PENABLE; endsequence
  sequence s_access; PSEL && PENABLE; endsequence
  a_ready_access: assert property (s_setup ##1 s_access |=> PREADY)
    else $error("no ready one cycle into access");
  a_ready_gated: assert property (PREADY |-> PSEL && PENABLE && $past(PENABLE))
    else $error("ready outside access phase");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (PREADY && !mapped |-> PSLVERR && (PWRITE || PRDATA == 32'h0))
    else $error("unmapped access not refused");
  a_status_write_ok: assert property (PREADY && mapped |-> !PSLVERR)
    else $error("mapped access refused");
  a_status_width: assert property (st_rd |-> PRDATA[31:8] == 24'h0)
    else $error("status upper bits not zero");
  a_err_with_full: assert property (st_rd && |PRDATA[2:0] |-> PRDATA[5])
    else $error("error flag without receive-full");
  a_tc_line_idle: assert property (st_rd && PRDATA[6] |-> PRDATA[7] && TXD && $past(TXD))
    else $error("tx complete while line busy");
endmodule
bind spsf_top spsf_chk i_chk (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .RXD(RXD), .TXD(TXD));
`default_nettype wire

// *** verification/spsf_node.sv ***
// remote serial node: drives the receive line and decodes the transmit line
// assumes one bit lasts BIT_CYC clock cycles and both lines idle high
`timescale 1ns/1ns
`default_nettype none
module spsf_node #(
  parameter int BIT_CYC = 16
) (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  // ==========================================================================
  // frame sender, lsb first; gl picks a frame bit with one flipped sample
  initial rxd = 1'b1;
  task automatic send_frame(input logic [11:0] f, input int n, input int gl);
    for (int i = 0; i < n; i++) begin
      for (int c = 0; c < BIT_CYC; c++) begin
        @(posedge clk);
        rxd <= (i == gl && c == 8) ? ~f[i] : f[i];
      end
    end
    @(posedge clk);
    rxd <= 1'b1;
  endtask
  // bounded wait so a silent transmitter cannot hang the run
  task automatic get_char(output logic [7:0] d);
    int k;
    k = 0;
    d = 8'h00;
    while (txd === 1'b1 && k < 1000) begin
      @(posedge clk);
      k++;
    end
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      d[i] = txd;
    end
  endtask
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench for the serial status-flag block
// assumes the partner node on the serial lines and an apb master in here
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic RXD;
  logic TXD;
  int errors = 0;
  int n_tests = 0;
  always #5 CLK = ~CLK;
  spsf_top i_dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .RXD(RXD), .TXD(TXD));
  spsf_node #(.BIT_CYC(16)) i_node (.clk(CLK), .txd(TXD), .rxd(RXD));
  // ==========================================================================
  // bus and compare helpers
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  // the request stands until ready is seen high at a rising edge; data taken there
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic er);
    int k;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    k = 0;
    @(posedge CLK);
    while (PREADY !== 1'b1 && k < 40) begin
      @(posedge CLK);
      k++;
    end
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (k >= 40) errors++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic r;
    apb(1'b1, a, v, d, r);
  endtask
  task automatic rdm(input string n, input logic [7:0] a, input logic [7:0] m,
      input logic [7:0] e);
    logic [31:0] d;
    logic r;
    apb(1'b0, a, 32'h0, d, r);
    chk(n, d & {24'hffffff, m}, {24'h0, e});
    chk("slverr", {31'h0, r}, {31'h0, a > spsf_pkg::ADDR_BAUD});
  endtask
  task automatic st(input logic [7:0] m, input logic [7:0] e);
    rdm("status", spsf_pkg::ADDR_STATUS, m, e);
  endtask
  task automatic dr(input logic [7:0] e, input logic [7:0] m);
    rdm("data", spsf_pkg::ADDR_DATA, m, e);
  endtask
  // ==========================================================================
  // scenarios
  task automatic s_regs();
    chk("txd reset", {31'h0, TXD}, 32'h1);
    st(8'hff, 8'hc0);
    rdm("ctrl", spsf_pkg::ADDR_CTRL, 8'hff, 8'h00);
    rdm("baud", spsf_pkg::ADDR_BAUD, 8'hff, 8'h36);
    wr(spsf_pkg::ADDR_STATUS, 32'hff);
    st(8'hff, 8'hc0);
    rdm("unmapped", 8'h10, 8'hff, 8'h00);
    wr(spsf_pkg::ADDR_BAUD, 32'h1);
  endtask
  task automatic s_tx();
    logic [7:0] c;
    logic hi;
    wr(spsf_pkg::ADDR_CTRL, 32'h08);
    st(8'hc0, 8'h80);
    repeat (200) @(posedge CLK);
    st(8'hc0, 8'hc0);
    wr(spsf_pkg::ADDR_DATA, 32'h5a);
    i_node.get_char(c);
    chk("tx byte", {24'h0, c}, 32'h5a);
    repeat (40) @(posedge CLK);
    // no status read since the last write, so this byte must stay queued
    wr(spsf_pkg::ADDR_DATA, 32'h33);
    hi = 1'b1;
    repeat (60) @(posedge CLK) hi = hi & TXD;
    chk("txd quiet", {31'h0, hi}, 32'h1);
    st(8'hc0, 8'hc0);
    wr(spsf_pkg::ADDR_CTRL, 32'h09);
    st(8'h40, 8'h00);
    wr(spsf_pkg::ADDR_CTRL, 32'h08);
  endtask
  task automatic rxc(input logic [7:0] c, input logic [8:0] d, input logic sb,
      input int gl, input logic [7:0] e, input logic [7:0] m);
    logic [11:0] f;
    f = c[spsf_pkg::CT_NINE] ? {1'b1, sb, d, 1'b0} : {2'b11, sb, d[7:0], 1'b0};
    wr(spsf_pkg::ADDR_CTRL, {24'h0, c});
    i_node.send_frame(f, c[spsf_pkg::CT_NINE] ? 11 : 10, gl);
    repeat (10) @(posedge CLK);
    st(8'h2f, e);
    dr(d[7:0] & m, m);
    st(8'h2f, 8'h00);
  endtask
  task automatic s_rx();
    int g[3] = '{0, 3, 9};
    rxc(8'h00, 9'h0a5, 1'b1, -1, 8'h20, 8'hff);
    foreach (g[i]) rxc(8'h00, 9'h0a5, 1'b1, g[i], 8'h24, 8'hff);
    rxc(8'h00, 9'h0a5, 1'b0, -1, 8'h22, 8'hff);
    rxc(8'h20, 9'h003, 1'b1, -1, 8'h20, 8'h7f);
    rxc(8'h20, 9'h083, 1'b1, -1, 8'h21, 8'h7f);
    rxc(8'h60, 9'h083, 1'b1, -1, 8'h20, 8'h7f);
    rxc(8'h30, 9'h103, 1'b1, -1, 8'h21, 8'hff);
  endtask
  task automatic s_idle();
    repeat (250) @(posedge CLK);
    st(8'h10, 8'h10);
    dr(8'h03, 8'hff);
    wr(spsf_pkg::ADDR_CTRL, 32'h00);
    i_node.send_frame(12'hffe, 10, -1);
    repeat (64) @(posedge CLK);
    st(8'h30, 8'h30);
    dr(8'hff, 8'hff);
    st(8'h30, 8'h00);
    repeat (300) @(posedge CLK);
    st(8'h10, 8'h00);
    wr(spsf_pkg::ADDR_CTRL, 32'h80);
    i_node.send_frame(12'hffe, 10, -1);
    repeat (140) @(posedge CLK);
    st(8'h30, 8'h20);
    repeat (48) @(posedge CLK);
    st(8'h30, 8'h30);
    dr(8'hff, 8'hff);
  endtask
  task automatic s_ovr();
    i_node.send_frame(12'he22, 10, -1);
    repeat (10) @(posedge CLK);
    st(8'h28, 8'h20);
    i_node.send_frame(12'he44, 10, -1);
    repeat (10) @(posedge CLK);
    dr(8'h11, 8'hff);
    st(8'h28, 8'h08);
    dr(8'h11, 8'hff);
    st(8'h28, 8'h00);
  endtask
  task automatic test_done();
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    s_regs();
    s_tx();
    s_rx();
    s_idle();
    s_ovr();
    test_done();
  end
  initial begin
    repeat (30000) @(posedge CLK);
    errors++;
    test_done();
  end
endmodule
`default_nettype wire
